// [core/vrts_top.sv]
// Shared reference and temperature sense control register with settle and interrupt logic
`timescale 1ns/1ps
module vrts_top
  import vrts_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [VRTS_AW-1:0] bus_addr,
  input wire logic [VRTS_DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [VRTS_DW-1:0] bus_rdata,
  output logic irq,
  output logic ref_enable,
  output logic ref_ready,
  output logic [VRTS_NBUF-1:0] buf_on,
  output logic [VRTS_NBUF-1:0] buf_gain_1x,
  output logic [VRTS_NBUF-1:0] buf_gain_2x,
  output logic [VRTS_NBUF-1:0] buf_gain_4x,
  output logic adc_ref_sel_buf1,
  output logic adc_chan_buf1_en,
  output logic adc_chan_buf2_en,
  output logic dac_ref_buf2_en,
  output logic cmp_ref_buf2_en,
  output logic temp_sense_enable,
  output logic temp_sense_range_select,
  output logic adc_chan_temp_en
);
  logic [VRTS_DW-1:0] ctrl_q;
  logic [VRTS_DW-1:0] rd_val;
  logic [VRTS_EVT_W-1:0] status_q;
  logic [VRTS_EVT_W-1:0] status_d;
  logic [VRTS_EVT_W-1:0] evt_set;
  logic [VRTS_EVT_W-1:0] evt_clr;
  logic [VRTS_EVT_W-1:0] mask_q;
  logic ready_prev_q;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic en_bit;
  logic buf1_sel;
  logic buf2_sel;

  vrts_settle_if sif ();

  // Address decode of the strobes
  assign wr_ctrl = bus_wr && (bus_addr == VRTS_CTRL_ADDR);
  assign wr_mask = bus_wr && (bus_addr == VRTS_MASK_ADDR);
  assign rd_stat = bus_rd && (bus_addr == VRTS_STAT_ADDR);

  // Control register, ready bit is not writable
  // shared control word
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ctrl_q <= VRTS_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= bus_wdata & VRTS_CTRL_WMASK;
  end

  // Interrupt mask register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      mask_q <= VRTS_MASK_RST;
    else if (wr_mask)
      mask_q <= bus_wdata[VRTS_EVT_W-1:0];
  end

  // Field views of the control word
  // reference enable bit
  assign en_bit = ctrl_q[VRTS_EN_BIT];
  assign sif.enable = en_bit;

  // Settling sequencer
  // enable starts the wait count
  vrts_settle u_settle
  (
    .mclk(mclk),
    .reset(reset),
    .sif(sif)
  );

  // One gain decoder per reference buffer
  // converter buffer gain
  generate
    for (genvar i = 0; i < VRTS_NBUF; i++)
    begin : g_buf
      vrts_gain_dec u_dec
      (
        .mclk(mclk),
        .reset(reset),
        .gain_code(vrts_gain_t'(ctrl_q[VRTS_BUF1_LSB + VRTS_GAIN_W*i +: VRTS_GAIN_W])),
        .ref_on(en_bit),
        .buf_on(buf_on[i]),
        .gain_1x(buf_gain_1x[i]),
        .gain_2x(buf_gain_2x[i]),
        .gain_4x(buf_gain_4x[i])
      );
    end
  endgenerate

  // Buffer is live when the reference runs and its gain is not off
  assign buf1_sel = en_bit && (ctrl_q[VRTS_BUF1_LSB +: VRTS_GAIN_W] != VRTS_GAIN_OFF);
  assign buf2_sel = en_bit && (ctrl_q[VRTS_BUF2_LSB +: VRTS_GAIN_W] != VRTS_GAIN_OFF);

  // Routing of the buffer outputs, aligned with the gain decoders
  // converter buffer routing
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      adc_ref_sel_buf1 <= 1'b0;
      adc_chan_buf1_en <= 1'b0;
      adc_chan_buf2_en <= 1'b0;
      dac_ref_buf2_en <= 1'b0;
      cmp_ref_buf2_en <= 1'b0;
    end
    else
    begin
      adc_ref_sel_buf1 <= buf1_sel;
      adc_chan_buf1_en <= buf1_sel;
      adc_chan_buf2_en <= buf2_sel;
      dac_ref_buf2_en <= buf2_sel;
      cmp_ref_buf2_en <= buf2_sel;
    end
  end

  // Temperature sensor controls and its dedicated converter channel
  // sensor enable
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      adc_chan_temp_en <= 1'b0;
    else
      adc_chan_temp_en <= ctrl_q[VRTS_SENSE_EN_BIT];
  end
  assign temp_sense_enable = ctrl_q[VRTS_SENSE_EN_BIT];
  assign temp_sense_range_select = ctrl_q[VRTS_SENSE_RNG_BIT];
  assign ref_enable = en_bit;
  assign ref_ready = sif.ready;

  // Ready edge history for event detection
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ready_prev_q <= 1'b0;
    else
      ready_prev_q <= sif.ready;
  end

  // Events: ready gained, ready lost; set wins over read clear
  always_comb
  begin
    evt_set = '0;
    evt_set[VRTS_EVT_READY] = sif.ready && !ready_prev_q;
    evt_set[VRTS_EVT_LOST] = !sif.ready && ready_prev_q;
    evt_clr = rd_stat ? '1 : '0;
    status_d = (status_q & ~evt_clr) | evt_set;
  end

  // Sticky event status
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      status_q <= VRTS_EVT_RST;
    else
      status_q <= status_d;
  end

  // Level interrupt while an unmasked event is pending
  assign irq = |(status_q & mask_q);

  // Read mux; unmapped addresses read zero
  // ready shown in bit 6
  always_comb
  begin
    rd_val = VRTS_ZERO;
    if (bus_addr == VRTS_CTRL_ADDR)
    begin
      rd_val = ctrl_q;
      rd_val[VRTS_RDY_BIT] = sif.ready;
    end
    else if (bus_addr == VRTS_STAT_ADDR)
      rd_val[VRTS_EVT_W-1:0] = status_q;
    else if (bus_addr == VRTS_MASK_ADDR)
      rd_val[VRTS_EVT_W-1:0] = mask_q;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      bus_rdata <= VRTS_ZERO;
    else if (bus_rd)
      bus_rdata <= rd_val;
    else
      bus_rdata <= VRTS_ZERO;
  end

  // Helper: cycles since the reference enable rose, saturating
  localparam int AST_N = VRTS_SETTLE_CYC;
  logic [VRTS_CNT_W:0] en_age_q;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      en_age_q <= '0;
    else if (!ref_enable)
      en_age_q <= '0;
    else if (en_age_q != '1)
      en_age_q <= en_age_q + 12'h001;
  end

  AST_CTRL_READBACK: assert property (@(posedge mclk) disable iff (reset)
    (bus_rd && bus_addr == VRTS_CTRL_ADDR) |=>
      (bus_rdata[5:0] == $past(ctrl_q[5:0])) && (bus_rdata[7] == $past(ctrl_q[7])))
    else $error("control readback mismatch");

  AST_BUF1_GAIN: assert property (@(posedge mclk) disable iff (reset)
    1'b1 |=> (buf_gain_4x[0] == ($past(ctrl_q[1:0]) == 2'b11 && $past(en_bit)))
      && (buf_on[0] == ($past(ctrl_q[1:0]) != 2'b00 && $past(en_bit))))
    else $error("converter buffer gain wrong");

  AST_BUF2_GAIN: assert property (@(posedge mclk) disable iff (reset)
    (en_bit && ctrl_q[3:2] == 2'b01) |=> buf_gain_1x[1] && !buf_gain_2x[1] && !buf_gain_4x[1])
    else $error("secondary buffer gain wrong");

  AST_ROUTE_BUF1: assert property (@(posedge mclk) disable iff (reset)
    (en_bit && ctrl_q[1:0] != 2'b00) |=> adc_ref_sel_buf1 && adc_chan_buf1_en)
    else $error("converter buffer not routed");

  AST_ROUTE_BUF2: assert property (@(posedge mclk) disable iff (reset)
    (en_bit && ctrl_q[3:2] != 2'b00) |=>
      dac_ref_buf2_en && cmp_ref_buf2_en && adc_chan_buf2_en)
    else $error("secondary buffer not routed");

  AST_EN_WRITE: assert property (@(posedge mclk) disable iff (reset)
    wr_ctrl |=> ref_enable == $past(bus_wdata[7]))
    else $error("enable write lost");

  AST_READY_OFF: assert property (@(posedge mclk) disable iff (reset)
    (bus_rd && bus_addr == VRTS_CTRL_ADDR && !ref_enable) |=> !bus_rdata[VRTS_RDY_BIT])
    else $error("ready read while disabled");

  AST_SETTLE_START: assert property (@(posedge mclk) disable iff (reset)
    $rose(ref_enable) |=> sif.settling)
    else $error("settling wait not started");

  AST_SENSE_EN_WRITE: assert property (@(posedge mclk) disable iff (reset)
    wr_ctrl |=> temp_sense_enable == $past(bus_wdata[5]))
    else $error("sensor enable write lost");

  AST_SENSE_RNG_WRITE: assert property (@(posedge mclk) disable iff (reset)
    wr_ctrl |=> temp_sense_range_select == $past(bus_wdata[4]))
    else $error("sensor range write lost");

  AST_TEMP_CHAN: assert property (@(posedge mclk) disable iff (reset)
    $rose(temp_sense_enable) |=> adc_chan_temp_en)
    else $error("temperature channel not granted");

  AST_READY_EARLY: assert property (@(posedge mclk) disable iff (reset)
    ref_ready |-> en_age_q >= AST_N)
    else $error("ready before settling");

  AST_READY_ON_TIME: assert property (@(posedge mclk) disable iff (reset)
    (ref_enable && en_age_q == AST_N) |-> ref_ready)
    else $error("ready late");

  AST_READY_DROP: assert property (@(posedge mclk) disable iff (reset)
    $fell(ref_enable) |-> !ref_ready ##1 status_q[VRTS_EVT_LOST] || !$past(ref_ready))
    else $error("ready not cleared on disable");

  AST_STATUS_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    (rd_stat && !(sif.ready ^ ready_prev_q)) |=> status_q == 2'b00)
    else $error("status not cleared by read");

  // Main scenarios
  COV_READY: cover property (@(posedge mclk) disable iff (reset) $rose(ref_ready));
  COV_LOST: cover property (@(posedge mclk) disable iff (reset) $fell(ref_ready));
  COV_IRQ: cover property (@(posedge mclk) disable iff (reset) $rose(irq));
  COV_CLR_SET: cover property (@(posedge mclk) disable iff (reset) rd_stat && |evt_set);
endmodule

// [pkg/vrts_pkg.sv]
// Constants and types shared by the reference and temperature sense control block
package vrts_pkg;
  // Register bus widths
  localparam int VRTS_AW = 12;
  localparam int VRTS_DW = 8;
  // Register byte addresses
  localparam logic [11:0] VRTS_CTRL_ADDR = 12'h20C;
  localparam logic [11:0] VRTS_STAT_ADDR = 12'h20D;
  localparam logic [11:0] VRTS_MASK_ADDR = 12'h20E;
  // Control field positions
  localparam int VRTS_EN_BIT = 7;
  localparam int VRTS_RDY_BIT = 6;
  localparam int VRTS_SENSE_EN_BIT = 5;
  localparam int VRTS_SENSE_RNG_BIT = 4;
  localparam int VRTS_BUF2_LSB = 2;
  localparam int VRTS_BUF1_LSB = 0;
  localparam int VRTS_GAIN_W = 2;
  localparam int VRTS_NBUF = 2;
  // Reset values and write mask of the control register
  localparam logic [7:0] VRTS_CTRL_RST = 8'h00;
  localparam logic [7:0] VRTS_CTRL_WMASK = 8'hBF;
  localparam logic [7:0] VRTS_ZERO = 8'h00;
  // Event status layout
  localparam int VRTS_EVT_W = 2;
  localparam int VRTS_EVT_READY = 0;
  localparam int VRTS_EVT_LOST = 1;
  localparam logic [1:0] VRTS_EVT_RST = 2'h0;
  localparam logic [1:0] VRTS_MASK_RST = 2'h0;
  // Settling time of the reference and buffers
  localparam int VRTS_CLK_NS = 20;
  localparam int VRTS_SETTLE_NS = 25000;
  localparam int VRTS_SETTLE_CYC = (VRTS_SETTLE_NS + VRTS_CLK_NS - 1) / VRTS_CLK_NS;
  localparam int VRTS_CNT_W = 11;
  localparam logic [10:0] VRTS_SETTLE_LOAD = 11'(VRTS_SETTLE_CYC - 1);
  localparam logic [10:0] VRTS_CNT_ONE = 11'h001;
  // Buffer gain codes
  typedef enum logic [1:0]
  {
    VRTS_GAIN_OFF = 2'b00,
    VRTS_GAIN_X1 = 2'b01,
    VRTS_GAIN_X2 = 2'b10,
    VRTS_GAIN_X4 = 2'b11
  } vrts_gain_t;
  // Settling sequencer states
  typedef enum logic [1:0]
  {
    VRTS_ST_IDLE = 2'b00,
    VRTS_ST_WAIT = 2'b01,
    VRTS_ST_READY = 2'b10
  } vrts_settle_t;
endpackage

// [pkg/vrts_settle_if.sv]
// Link between the control register and the settling sequencer
`timescale 1ns/1ps
interface vrts_settle_if;
  logic enable;
  logic ready;
  logic settling;
  modport ctrl (output enable, input ready, input settling);
  modport timer (input enable, output ready, output settling);
endinterface

// [core/vrts_gain_dec.sv]
// Gain field decoder for one reference buffer
`timescale 1ns/1ps
module vrts_gain_dec
  import vrts_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire vrts_gain_t gain_code,
  input wire logic ref_on,
  output logic buf_on,
  output logic gain_1x,
  output logic gain_2x,
  output logic gain_4x
);
  vrts_gain_t eff_code;

  // A buffer has nothing to amplify while the reference is off
  assign eff_code = ref_on ? gain_code : VRTS_GAIN_OFF;

  // Registered one-hot gain selection
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      {buf_on, gain_1x, gain_2x, gain_4x} <= 4'h0;
    end
    else
    begin
      case (eff_code)
        VRTS_GAIN_X1: {buf_on, gain_1x, gain_2x, gain_4x} <= 4'hC;
        VRTS_GAIN_X2: {buf_on, gain_1x, gain_2x, gain_4x} <= 4'hA;
        VRTS_GAIN_X4: {buf_on, gain_1x, gain_2x, gain_4x} <= 4'h9;
        default: {buf_on, gain_1x, gain_2x, gain_4x} <= 4'h0;
      endcase
    end
  end
endmodule

// [core/vrts_settle.sv]
// Settling sequencer that raises the ready flag after a fixed wait
`timescale 1ns/1ps
module vrts_settle
  import vrts_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  vrts_settle_if.timer sif
);
  vrts_settle_t st_q;
  logic [VRTS_CNT_W-1:0] cnt_q;

  // State and wait counter; a low enable aborts at once
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= VRTS_ST_IDLE;
      cnt_q <= '0;
    end
    else if (!sif.enable)
    begin
      st_q <= VRTS_ST_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (st_q)
        VRTS_ST_IDLE:
        begin
          st_q <= VRTS_ST_WAIT;
          cnt_q <= VRTS_SETTLE_LOAD;
        end
        VRTS_ST_WAIT:
        begin
          if (cnt_q == VRTS_CNT_ONE)
            st_q <= VRTS_ST_READY;
          else
            cnt_q <= cnt_q - VRTS_CNT_ONE;
        end
        VRTS_ST_READY: st_q <= VRTS_ST_READY;
        default: st_q <= VRTS_ST_IDLE;
      endcase
    end
  end

  // Ready is gated by enable so it drops in the same cycle
  // ready after wait
  assign sif.ready = (st_q == VRTS_ST_READY) && sif.enable;
  assign sif.settling = (st_q == VRTS_ST_WAIT);
endmodule

// [test/vrts_analog_model.sv]
// Behavioural model of the analog reference buffers and temperature sensing circuit
`timescale 1ns/1ps
module vrts_analog_model
  import vrts_pkg::*;
#(
  parameter int VT_MV = 600
)
(
  input wire logic ref_enable,
  input wire logic [VRTS_NBUF-1:0] buf_on,
  input wire logic [VRTS_NBUF-1:0] buf_gain_1x,
  input wire logic [VRTS_NBUF-1:0] buf_gain_2x,
  input wire logic [VRTS_NBUF-1:0] buf_gain_4x,
  input wire logic temp_sense_enable,
  input wire logic temp_sense_range_select,
  output logic [15:0] conv_ref_mv,
  output logic [15:0] sec_ref_mv,
  output logic [15:0] temp_mv
);
  logic [15:0] buf_mv [VRTS_NBUF];

  always_comb
  begin
    for (int i = 0; i < VRTS_NBUF; i++)
    begin
      buf_mv[i] = 16'h0000;
      if (ref_enable && buf_on[i])
      begin
        if (buf_gain_1x[i]) buf_mv[i] = 16'h0400;
        else if (buf_gain_2x[i]) buf_mv[i] = 16'h0800;
        else if (buf_gain_4x[i]) buf_mv[i] = 16'h1000;
      end
    end
  end

  // Converter buffer and secondary buffer outputs
  assign conv_ref_mv = buf_mv[0];
  assign sec_ref_mv = buf_mv[1];

  assign temp_mv = !temp_sense_enable ? 16'h0000 :
                   16'(temp_sense_range_select ? 3 * VT_MV : 2 * VT_MV);
endmodule

// [test/vrts_top_tb_top.sv]
// Self-checking testbench for the reference and temperature sense control block
`timescale 1ns/1ps
module vrts_top_tb_top
  import vrts_pkg::*;
;
  logic mclk, reset, bus_wr, bus_rd;
  logic [11:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata;
  logic irq, ref_enable, ref_ready, adc_ref_sel_buf1, adc_chan_buf1_en;
  logic adc_chan_buf2_en, dac_ref_buf2_en, cmp_ref_buf2_en;
  logic temp_sense_enable, temp_sense_range_select, adc_chan_temp_en;
  logic [1:0] buf_on, buf_gain_1x, buf_gain_2x, buf_gain_4x;
  logic [15:0] conv_ref_mv, sec_ref_mv, temp_mv;
  int fails = 0;
  int comparisons = 0;

  vrts_top u_vrts_top (.mclk(mclk), .reset(reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .irq(irq), .ref_enable(ref_enable), .ref_ready(ref_ready), .buf_on(buf_on),
    .buf_gain_1x(buf_gain_1x), .buf_gain_2x(buf_gain_2x), .buf_gain_4x(buf_gain_4x),
    .adc_ref_sel_buf1(adc_ref_sel_buf1), .adc_chan_buf1_en(adc_chan_buf1_en),
    .adc_chan_buf2_en(adc_chan_buf2_en), .dac_ref_buf2_en(dac_ref_buf2_en),
    .cmp_ref_buf2_en(cmp_ref_buf2_en), .temp_sense_enable(temp_sense_enable),
    .temp_sense_range_select(temp_sense_range_select),
    .adc_chan_temp_en(adc_chan_temp_en));

  vrts_analog_model u_vrts_analog_model (.ref_enable(ref_enable), .buf_on(buf_on),
    .buf_gain_1x(buf_gain_1x), .buf_gain_2x(buf_gain_2x), .buf_gain_4x(buf_gain_4x),
    .temp_sense_enable(temp_sense_enable),
    .temp_sense_range_select(temp_sense_range_select),
    .conv_ref_mv(conv_ref_mv), .sec_ref_mv(sec_ref_mv), .temp_mv(temp_mv));

  // Clock generation, 20 ns period
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Compare one value and count the outcome
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  // Print counts and verdict, then end the run
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  // One-cycle register read, data judged in the following cycle
  task automatic rd_chk(input string n, input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    check(n, 16'(bus_rdata), 16'(e));
  endtask

  // Reset values, unmapped and read-only places
  task automatic test_reset();
    rd_chk("ctrl_rst", VRTS_CTRL_ADDR, 8'h00);
    @(posedge mclk);
    #1;
    check("rdata_idle", 16'(bus_rdata), 16'h0000);
    check("outs_rst", 16'({ref_enable, ref_ready, temp_sense_enable, irq}), 16'h0000);
    rd_chk("mask_rst", VRTS_MASK_ADDR, 8'h00);
    wr(12'h210, 8'hFF);
    wr(VRTS_STAT_ADDR, 8'hFF);
    rd_chk("unmapped", 12'h210, 8'h00);
    rd_chk("stat_ro", VRTS_STAT_ADDR, 8'h00);
    rd_chk("ctrl_kept", VRTS_CTRL_ADDR, 8'h00);
    $display("test_reset done");
  endtask

  // Settling count, ready events and interrupt masking
  task automatic test_settle();
    int n;
    wr(VRTS_MASK_ADDR, 8'h01);
    wr(VRTS_CTRL_ADDR, 8'h80);
    #1;
    check("en_rise", 16'(ref_enable), 16'h0001);
    for (n = 1; n <= 2000; n++)
    begin
      @(posedge mclk);
      #1;
      if (ref_ready === 1'b1) break;
    end
    if (n > 2000)
    begin
      fails++;
      stop_test();
    end
    check("settle_cycles", 16'(n), 16'(VRTS_SETTLE_CYC));
    @(posedge mclk);
    #1;
    check("irq_gain", 16'(irq), 16'h0001);
    rd_chk("ctrl_ready", VRTS_CTRL_ADDR, 8'hC0);
    rd_chk("stat_gain", VRTS_STAT_ADDR, 8'h01);
    check("irq_clr", 16'(irq), 16'h0000);
    rd_chk("stat_empty", VRTS_STAT_ADDR, 8'h00);
    wr(VRTS_MASK_ADDR, 8'h02);
    wr(VRTS_CTRL_ADDR, 8'h40);
    #1;
    check("drop", 16'({ref_enable, ref_ready}), 16'h0000);
    @(posedge mclk);
    #1;
    check("irq_lost", 16'(irq), 16'h0001);
    rd_chk("ctrl_ro", VRTS_CTRL_ADDR, 8'h00);
    rd_chk("stat_lost", VRTS_STAT_ADDR, 8'h02);
    check("irq_clr2", 16'(irq), 16'h0000);
    rd_chk("mask_rb", VRTS_MASK_ADDR, 8'h02);
    $display("test_settle done");
  endtask

  // Every gain code on both buffers, with routing and levels
  task automatic test_gain();
    logic [7:0] d;
    logic [1:0] on, g1, g2, g4;
    for (int c1 = 0; c1 < 4; c1++)
    begin
      for (int c2 = 0; c2 < 4; c2++)
      begin
        d = 8'h80 | 8'(c2 << 2) | 8'(c1);
        on = {c2 != 0, c1 != 0};
        g1 = {c2 == 1, c1 == 1};
        g2 = {c2 == 2, c1 == 2};
        g4 = {c2 == 3, c1 == 3};
        wr(VRTS_CTRL_ADDR, d);
        @(posedge mclk);
        #1;
        check("buf_on", 16'(buf_on), 16'(on));
        check("gains", 16'({buf_gain_4x, buf_gain_2x, buf_gain_1x}),
              16'({g4, g2, g1}));
        check("buf1_route", 16'({adc_ref_sel_buf1, adc_chan_buf1_en}),
              16'({2{on[0]}}));
        check("buf2_route", 16'({adc_chan_buf2_en, dac_ref_buf2_en, cmp_ref_buf2_en}),
              16'({3{on[1]}}));
        check("conv_mv", conv_ref_mv, (c1 == 0) ? 16'h0 : 16'(1024 << (c1 - 1)));
        check("sec_mv", sec_ref_mv, (c2 == 0) ? 16'h0 : 16'(1024 << (c2 - 1)));
        rd_chk("ctrl_gain", VRTS_CTRL_ADDR, d);
      end
    end
    wr(VRTS_CTRL_ADDR, 8'h0F);
    @(posedge mclk);
    #1;
    check("buf_off_dis", 16'({buf_on, adc_chan_buf1_en, dac_ref_buf2_en}), 16'h0000);
    $display("test_gain done");
  endtask

  // Sensor enable and range, with the dedicated channel one cycle later
  task automatic test_temp();
    logic [1:0] prev;
    logic [1:0] v;
    prev = 2'b00;
    for (int i = 0; i < 5; i++)
    begin
      v = 2'(i == 4 ? 0 : 3 - i);
      wr(VRTS_CTRL_ADDR, {2'b00, v, 4'h0});
      #1;
      check("ts_bits", 16'({temp_sense_enable, temp_sense_range_select}), 16'(v));
      check("ts_chan_old", 16'(adc_chan_temp_en), 16'(prev[1]));
      @(posedge mclk);
      #1;
      check("ts_chan", 16'(adc_chan_temp_en), 16'(v[1]));
      check("ts_mv", temp_mv, !v[1] ? 16'h0 : (v[0] ? 16'd1800 : 16'd1200));
      rd_chk("ctrl_ts", VRTS_CTRL_ADDR, {2'b00, v, 4'h0});
      prev = v;
    end
    $display("test_temp done");
  endtask

  // Main sequence
  initial
  begin
    reset = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 12'h000;
    bus_wdata = 8'h00;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    test_reset();
    test_settle();
    test_gain();
    test_temp();
    stop_test();
  end
endmodule
